// ===== tb/calsg_ctl.sv
`timescale 1ns/1ps
// ==========
// remote controller model
module calsg_ctl
	import calsg_pkg::*;
(
	input  wire logic        core_clk,   // clock
	input  wire logic        resp_valid, // answer valid
	input  wire logic [15:0] resp_data,  // answer
	output calsg_cmd_s       cmd         // command
);
	initial cmd = '0;
	// one command, held over its taking edge; idle wdata inverted, never stale
	task automatic xfer(input logic p, w, input logic [2:0] s, input logic [15:0] d,
		output logic [15:0] r, output logic ok);
		@(negedge core_clk);
		cmd <= '{1'b1, w, calsg_path_e'(p), s, d};
		@(negedge core_clk);
		cmd <= '{1'b0, 1'b0, calsg_path_e'(p), 3'h7, ~d};
		ok = resp_valid === !w;
		r = resp_data;
	endtask
endmodule

// ===== tb/calsg_top_sva.sv
`timescale 1ns/1ps
// ==========
// port checks
module calsg_top_sva
	import calsg_pkg::*;
(
	input  wire logic        core_clk,          // clock
	input  wire logic        rst,               // reset
	input  calsg_cmd_s       cmd,               // command
	input  wire logic        clear_status,      // clear pulse
	input  calsg_evt_s       evt,               // activity
	input  wire logic        resp_valid,        // answer valid
	input  wire logic [15:0] resp_data,         // answer
	input  wire logic        caling_summary,    // calibrating summary
	input  wire logic        cal_fault_summary, // failure summary
	input  wire logic [7:0]  stb_contrib        // status byte
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire	is_q	= cmd.valid && !cmd.write;
	wire	is_f	= cmd.path == CALSG_PATH_CAL_FAIL;
	a_stb_bit_three: assert property (stb_contrib == {4'h0, cal_fault_summary, 3'h0})
		else $error("bad status byte");
	a_query_answered: assert property (is_q |=> resp_valid)
		else $error("query unanswered");
	a_write_silent: assert property (!is_q |=> !resp_valid)
		else $error("stray answer");
	a_fail_unused_zero: assert property (is_q && is_f |=> resp_data[15:9] == 7'h0 && !resp_data[7])
		else $error("unused failure bit set");
	a_caling_high_zero: assert property (is_q && !is_f |=> resp_data[15:4] == 12'h0)
		else $error("unused calibrating bit set");
	a_caling_cond_zero: assert property (is_q && !is_f && cmd.reg_sel == 3'h0 |=> resp_data == 16'h0)
		else $error("calibrating condition true");
	a_bad_sel_zero: assert property (is_q && cmd.reg_sel > 3'h4 |=> resp_data == 16'h0)
		else $error("reserved read nonzero");
	a_clear_summary: assert property (clear_status && evt[11:8] == 4'h0 && evt[3:0] == 4'h0
		&& $stable(evt[7:4]) |=> ##1 !caling_summary && !cal_fault_summary) else $error("summary after clear");
endmodule
bind calsg_top calsg_top_sva u_sva (.core_clk, .rst, .cmd, .clear_status, .evt, .resp_valid, .resp_data,
	.caling_summary, .cal_fault_summary, .stb_contrib);

// ===== tb/testbench.sv
`timescale 1ns/1ps
module testbench import calsg_pkg::*;;
	logic		core_clk, rst, clear_status, resp_valid, caling_summary, cal_fault_summary, ok;
	logic [15:0]	resp_data, r, lv, pm, nm, m, old;
	logic [7:0]	stb_contrib;
	logic [2:0]	sl[3] = '{3'h1, 3'h2, 3'h4};
	calsg_cmd_s	cmd;
	calsg_evt_s	evt;
	int		mismatches, total_checks, seed, i, g;
	int		model_reg[2][8];
	calsg_top uut (.core_clk, .rst, .cmd, .clear_status, .evt, .resp_valid, .resp_data,
		.caling_summary, .cal_fault_summary, .stb_contrib);
	calsg_ctl ctl (.core_clk, .resp_valid, .resp_data, .cmd);
	function automatic logic [15:0] msk(input int p);
		return p ? 16'h017F : 16'h000F;
	endfunction
	task automatic chk(input string n, input logic [15:0] s, x);
		total_checks++;
		if (s !== x) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", n, x, s);
		end
	endtask
	task automatic rd(input int p, input logic [2:0] s, input logic [15:0] x, input string n);
		ctl.xfer(p[0], 1'b0, s, 16'h0, r, ok);
		chk("answer", {15'h0, ok}, 16'h1);
		chk(n, r, x);
	endtask
	task automatic wr(input int p, input logic [2:0] s, input logic [15:0] d);
		ctl.xfer(p[0], 1'b1, s, d, r, ok);
		chk("silent", {15'h0, ok}, 16'h1);
		// model keeps only the three writable masks; other selectors ignore writes
		if (s == 3'h1 || s == 3'h2 || s == 3'h4)
			model_reg[p][s] = int'(d & msk(p));
	endtask
	task automatic model_reset;
		for (int a = 0; a < 2; a++) begin
			for (int b = 0; b < 8; b++)
				model_reg[a][b] = 0;
			model_reg[a][1] = int'(msk(a));
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	// ==========
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		summarize;
	end
	initial begin
		seed = 32'h95438A50;
		rst = 1;
		clear_status = 0;
		evt = '0;
		model_reset;
		repeat (12) @(posedge core_clk);
		@(negedge core_clk) rst = 0;
		for (g = 0; g < 2; g++) begin
			rd(g, 3'h1, 16'(model_reg[g][1]), "ptr reset");
			rd(g, 3'h2, 16'(model_reg[g][2]), "ntr reset");
			rd(g, 3'h4, 16'(model_reg[g][4]), "enable reset");
			wr(g, 3'(5 + g), 16'hFFFF);
			rd(g, 3'(5 + g), 16'h0000, "reserved");
			wr(g, 3'h0, 16'hFFFF);
			rd(g, 3'h0, 16'h0000, "cond idle");
		end
		$display("reset test done");
		for (i = 0; i < 18; i++) begin
			lv = 16'($random(seed));
			wr(i % 2, sl[i % 3], lv);
			rd(i % 2, sl[i % 3], 16'(model_reg[i % 2][sl[i % 3]]), "readback");
		end
		$display("mask test done");
		for (i = 0; i < 6; i++) begin
			lv = 16'($random(seed));
			@(negedge core_clk) evt = {lv[7:4], 4'h0, lv[3:0]};
			@(negedge core_clk) evt = '0;
			rd(1, 3'h3, {7'h0, lv[3], 1'b0, lv[2:0], 4'h0}, "pulse event");
			rd(1, 3'h3, 16'h0000, "event requery");
			rd(0, 3'h3, {12'h0, lv[7:4]}, "start event");
		end
		$display("pulse test done");
		pm = 16'($random(seed));
		nm = 16'($random(seed));
		wr(1, 3'h1, pm);
		wr(1, 3'h2, nm);
		m = 16'h0000;
		old = 16'h0000;
		for (i = 0; i < 10; i++) begin
			lv = 16'($random(seed)) & 16'h000F;
			@(negedge core_clk) evt[7:4] = lv[3:0];
			m |= (lv & ~old & pm) | (~lv & old & nm);
			old = lv;
			rd(1, 3'h0, lv, "live cond");
		end
		rd(1, 3'h3, m, "filtered event");
		$display("filter test done");
		// stand-in for the parent groups: their summary enables are assumed set
		wr(1, 3'h4, 16'h0100);
		wr(0, 3'h4, 16'h0004);
		@(negedge core_clk) evt = 12'h408;
		@(negedge core_clk) evt = '0;
		repeat (2) @(negedge core_clk);
		chk("fault sum", {15'h0, cal_fault_summary}, 16'h1);
		chk("cal sum", {15'h0, caling_summary}, 16'h1);
		chk("stb", {8'h0, stb_contrib}, 16'h8);
		@(negedge core_clk) clear_status = 1;
		@(negedge core_clk) clear_status = 0;
		repeat (2) @(negedge core_clk);
		chk("stb clr", {8'h0, stb_contrib}, 16'h0);
		rd(0, 3'h3, 16'h0000, "cleared event");
		rd(1, 3'h4, 16'(model_reg[1][4]), "enable");
		$display("summary test done");
		// second reset in mid-run: written masks must fall back
		@(negedge core_clk) rst = 1;
		repeat (2) @(negedge core_clk);
		rst = 0;
		model_reset;
		chk("sum reset", {14'h0, caling_summary, cal_fault_summary}, 16'h0000);
		for (g = 0; g < 2; g++) begin
			rd(g, 3'h1, 16'(model_reg[g][1]), "ptr rerun");
			rd(g, 3'h2, 16'(model_reg[g][2]), "ntr rerun");
			rd(g, 3'h4, 16'(model_reg[g][4]), "enable rerun");
		end
		$display("reset rerun test done");
		summarize;
	end
endmodule

// ===== verilog/calsg_defs.svh
// Overview of operation
// - event register clears on query or clear-status
// - failure summary drives status byte bit three
// - failure bits 15..9 and 7 read zero
// - failure bit 8 latches baseband channel error
// - failure bit 6 latches channel power failure
// - failure bit 5 latches power zeroing failure
// - failure bit 4 latches tx auto-zero failure
// - failure bits 3..0 live self-cal conditions
// - condition register readable by condition query
// - transition filters readable and writable masks
// - enable register readable returns last written value ANDed with the implemented bit mask
// - calibrating under operation, failure under calibration path
// - both groups use 16-bit registers
// - calibrating bits 0..3 latch calibration starts
// - calibrating condition query never shows true
`ifndef CALSG_DEFS_SVH
`define CALSG_DEFS_SVH

// ==========================================================
// register selectors within a group
`define CALSG_REG_COND   3'h0
`define CALSG_REG_PTR    3'h1
`define CALSG_REG_NTR    3'h2
`define CALSG_REG_EVENT  3'h3
`define CALSG_REG_ENABLE 3'h4

// ==========================================================
// implemented bit masks
`define CALSG_CALING_MASK   16'h000F
`define CALSG_FAIL_MASK     16'h017F
`define CALSG_FAIL_LIVE     16'h000F
`define CALSG_FAIL_EVONLY   16'h0170

// ==========================================================
// reset values and status byte position
`define CALSG_PTR_RST       16'hFFFF
`define CALSG_NTR_RST       16'h0000
`define CALSG_ENABLE_RST    16'h0000
`define CALSG_STB_FAIL_BIT  3

`endif

// ===== verilog/calsg_group.sv
`timescale 1ns/1ps
`include "calsg_defs.svh"

module calsg_group
	import calsg_pkg::*;
#(
	parameter int          WIDTH      = 16,
	parameter logic [15:0] IMPL_MASK  = 16'hFFFF,
	parameter logic [15:0] COND_MASK  = 16'hFFFF
) (
	input  wire logic             core_clk,   // system clock
	input  wire logic             rst,        // sync reset, high
	input  wire logic [WIDTH-1:0] cond_in,    // live condition levels
	input  wire logic [WIDTH-1:0] direct_set, // event-only set pulses
	input  wire logic             sel,        // command targets this group
	input  wire logic             wr,         // write strobe
	input  wire logic [2:0]       reg_sel,    // register selector
	input  wire logic [WIDTH-1:0] wdata,      // write mask
	input  wire logic             clr_all,    // clear-status command
	output logic      [WIDTH-1:0] rdata,      // selected register value
	output logic                  summary     // summary message bit
);

	// the masks and reset values are 16-bit wide; refuse any other width at elaboration
	if (WIDTH != 16) begin : g_width_check
		$error("calsg_group: WIDTH must be 16");
	end

	logic [WIDTH-1:0] cond_q, ptr_q, ntr_q, event_q, enable_q;
	logic [WIDTH-1:0] rise, fall, set_bits;
	logic             ev_query;

	// ==========================================================
	// condition tracking and transition detect
	always_ff @(posedge core_clk) begin
		if (rst)
			cond_q <= '0;
		else
			cond_q <= cond_in & COND_MASK;
	end

	assign rise     = (cond_in & COND_MASK) & ~cond_q;
	assign fall     = ~(cond_in & COND_MASK) & cond_q;
	// edge filters plus direct pulses; unused bits never set
	assign set_bits = ((rise & ptr_q) | (fall & ntr_q) | direct_set) & IMPL_MASK;
	assign ev_query = sel && !wr && reg_sel == `CALSG_REG_EVENT;

	// ==========================================================
	// writable masks
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ptr_q    <= `CALSG_PTR_RST & IMPL_MASK;
			ntr_q    <= `CALSG_NTR_RST;
			enable_q <= `CALSG_ENABLE_RST;
		end else if (sel && wr) begin
			case (reg_sel)
				`CALSG_REG_PTR:    ptr_q    <= wdata & IMPL_MASK;
				`CALSG_REG_NTR:    ntr_q    <= wdata & IMPL_MASK;
				`CALSG_REG_ENABLE: enable_q <= wdata & IMPL_MASK;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// event latch; a set in the clearing cycle survives
	always_ff @(posedge core_clk) begin
		if (rst)
			event_q <= '0;
		else if (ev_query || clr_all)
			event_q <= set_bits;
		else
			event_q <= event_q | set_bits;
	end

	// ==========================================================
	// read mux and summary
	always_ff @(posedge core_clk) begin
		if (rst)
			rdata <= '0;
		else if (sel && !wr) begin
			case (reg_sel)
				`CALSG_REG_COND:   rdata <= cond_q;
				`CALSG_REG_PTR:    rdata <= ptr_q;
				`CALSG_REG_NTR:    rdata <= ntr_q;
				`CALSG_REG_EVENT:  rdata <= event_q;
				`CALSG_REG_ENABLE: rdata <= enable_q;
				default:           rdata <= '0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			summary <= 1'b0;
		else
			summary <= |(event_q & enable_q);
	end

endmodule

// ===== verilog/calsg_pkg.sv
package calsg_pkg;

	typedef enum logic {
		CALSG_PATH_OPER_CALING,
		CALSG_PATH_CAL_FAIL
	} calsg_path_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		calsg_path_e path;
		logic [2:0]  reg_sel;
		logic [15:0] wdata;
	} calsg_cmd_s;

	typedef struct packed {
		logic [3:0] baseband_start;
		logic       voltmeter_fail;
		logic       counter_fail;
		logic       sampler_fail;
		logic       specan_fail;
		logic       baseband_err_pulse;
		logic       chan_power_fail_pulse;
		logic       zeroing_fail_pulse;
		logic       tx_autozero_fail_pulse;
	} calsg_evt_s;

endpackage

// ===== verilog/calsg_top.sv
`timescale 1ns/1ps
`include "calsg_defs.svh"

module calsg_top
	import calsg_pkg::*;
(
	input  wire logic       core_clk,           // system clock, 100 MHz
	input  wire logic       rst,                // sync reset, high
	input  calsg_cmd_s      cmd,                // decoded status command
	input  wire logic       clear_status,       // clear-status common command pulse
	input  calsg_evt_s      evt,                // calibration activity inputs
	output logic            resp_valid,         // query answer valid
	output logic [15:0]     resp_data,          // query answer integer
	output logic            caling_summary,     // calibrating summary, to operation group
	output logic            cal_fault_summary,  // failure summary, to questionable group
	output logic [7:0]      stb_contrib         // status byte contribution
);

	logic [15:0] caling_rdata, fault_rdata;
	logic [15:0] caling_set, fault_cond, fault_set;
	logic        sel_caling, sel_fault;
	calsg_path_e path_q;

	// ==========================================================
	// path decode
	assign sel_caling = cmd.valid && cmd.path == CALSG_PATH_OPER_CALING;
	assign sel_fault  = cmd.valid && cmd.path == CALSG_PATH_CAL_FAIL;

	// calibration starts latch as events only: condition never observable
	assign caling_set = {12'h000, evt.baseband_start};
	assign fault_cond = {12'h000, evt.voltmeter_fail, evt.counter_fail,
	                     evt.sampler_fail, evt.specan_fail};
	assign fault_set  = {7'h00, evt.baseband_err_pulse, 1'b0, evt.chan_power_fail_pulse,
	                     evt.zeroing_fail_pulse, evt.tx_autozero_fail_pulse, 4'h0};

	calsg_group #(
		.WIDTH     (16),
		.IMPL_MASK (`CALSG_CALING_MASK),
		.COND_MASK (16'h0000)
	) u_caling (
		.core_clk   (core_clk),
		.rst        (rst),
		.cond_in    (16'h0000),
		.direct_set (caling_set),
		.sel        (sel_caling),
		.wr         (cmd.write),
		.reg_sel    (cmd.reg_sel),
		.wdata      (cmd.wdata),
		.clr_all    (clear_status),
		.rdata      (caling_rdata),
		.summary    (caling_summary)
	);

	calsg_group #(
		.WIDTH     (16),
		.IMPL_MASK (`CALSG_FAIL_MASK),
		.COND_MASK (`CALSG_FAIL_LIVE)
	) u_fault (
		.core_clk   (core_clk),
		.rst        (rst),
		.cond_in    (fault_cond),
		.direct_set (fault_set & `CALSG_FAIL_EVONLY),
		.sel        (sel_fault),
		.wr         (cmd.write),
		.reg_sel    (cmd.reg_sel),
		.wdata      (cmd.wdata),
		.clr_all    (clear_status),
		.rdata      (fault_rdata),
		.summary    (cal_fault_summary)
	);

	// ==========================================================
	// answer return, one cycle after the query
	always_ff @(posedge core_clk) begin
		if (rst) begin
			resp_valid <= 1'b0;
			path_q     <= CALSG_PATH_OPER_CALING;
		end else begin
			resp_valid <= cmd.valid && !cmd.write;
			// only a query moves the path, so the answer holds until the next query
			if (cmd.valid && !cmd.write)
				path_q <= cmd.path;
		end
	end

	assign resp_data = (path_q == CALSG_PATH_CAL_FAIL) ? fault_rdata : caling_rdata;

	// parent gating stays outside; this is the raw bit-three feed
	assign stb_contrib = {7'h00, cal_fault_summary} << `CALSG_STB_FAIL_BIT;

endmodule
